// ---- core/rta_alarm.sv ----
`timescale 1ns/1ps
`include "rta_consts.svh"
module rta_alarm (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   sclk,
	input  wire logic                   sdio_i,
	output logic                        sdio_o,
	output logic                        sdio_oe,
	input  wire logic                   int_n_i,
	output logic                        int_n_o,
	output logic                        int_n_oe,
	output logic                        int_line_low,
	input  wire rta_pkg::rta_counters_t counters,
	input  wire logic                   minute_tick,
	output logic                        cnt_wr,
	output logic [3:0]                  cnt_wr_addr,
	output logic [7:0]                  cnt_wr_data
);

	rta_pkg::rta_state_t st_reg;
	rta_pkg::rta_state_t st_next;

	logic       sclk_rise;
	logic       match_min;
	logic       match_hour;
	logic       match_day;
	logic       alarm_event;
	logic       wr_en;
	logic [7:0] wr_data;
	logic [3:0] wr_addr;
	logic [7:0] shift_in;
	logic [3:0] addr_inc;

	// one bcd field against its counter, skipped when disabled
	function automatic logic field_ok(input logic [7:0] al, input logic [7:0] cnt,
	                                  input logic [7:0] mask);
		field_ok = al[`RTA_BIT_DISABLE] | ((al & mask) == (cnt & mask)); // see (R13) (R15)
	endfunction

	function automatic logic [7:0] reg_read(input rta_pkg::rta_state_t s,
	                                        input rta_pkg::rta_counters_t c,
	                                        input logic [3:0] a);
		reg_read = `RTA_RST_BYTE;
		case (a)
			`RTA_ADR_MIN:     reg_read = c.minute;
			`RTA_ADR_HOUR:    reg_read = c.hour;
			`RTA_ADR_WDAY:    reg_read = c.weekday;
			`RTA_ADR_DATE:    reg_read = c.date;
			`RTA_ADR_MIN_AL:  reg_read = s.min_alarm;
			`RTA_ADR_HOUR_AL: reg_read = s.hour_alarm; // see (R16)
			`RTA_ADR_DAY_AL:  reg_read = s.day_alarm;
			`RTA_ADR_EXT:     reg_read = s.extension_control;
			`RTA_ADR_FLAG:    reg_read[`RTA_BIT_AFLAG] = s.alarm_flag;
			`RTA_ADR_CTRL:    reg_read = s.interrupt_control & `RTA_MASK_CTRL; // see (R16)
			default:          reg_read = `RTA_RST_BYTE;
		endcase
	endfunction

	assign sclk_rise = st_reg.sclk_s2 & ~st_reg.sclk_s3;
	assign shift_in  = {st_reg.shift[6:0], st_reg.sdi_s2};
	assign addr_inc  = st_reg.addr + `RTA_ADR_ONE; // wraps f to 0, see (R19)

	// alarm compare
	assign match_min  = field_ok(st_reg.min_alarm, counters.minute, `RTA_MASK_MIN); // see (R1)
	assign match_hour = field_ok(st_reg.hour_alarm, counters.hour, `RTA_MASK_HOUR);

	always_comb begin
		if (st_reg.day_alarm[`RTA_BIT_DISABLE]) begin
			match_day = 1'b1; // see (R13) (R14)
		end else if (st_reg.extension_control[`RTA_BIT_DAYSEL]) begin
			match_day = field_ok(st_reg.day_alarm, counters.date, `RTA_MASK_DATE); // see (R11)
		end else begin
			match_day = |(st_reg.day_alarm[6:0] & counters.weekday[6:0] & `RTA_MASK_WDAY); // see (R12)
		end
	end

	// only on the counter update entering the minute
	assign alarm_event = minute_tick & match_min & match_hour & match_day // see (R2) (R20)
	                     & ~st_reg.interrupt_control[`RTA_BIT_SWRST]; // see (R10)

	// serial write strobe
	assign wr_en   = st_reg.ce_s2 & sclk_rise & (st_reg.phase == rta_pkg::RTA_DATA)
	                 & ~st_reg.read_mode & (st_reg.bit_cnt == `RTA_BYTE_LAST);
	assign wr_data = shift_in;
	assign wr_addr = st_reg.addr;

	always_comb begin
		st_next = st_reg;
		st_next.ce_s1   = ce;
		st_next.ce_s2   = st_reg.ce_s1;
		st_next.sclk_s1 = sclk;
		st_next.sclk_s2 = st_reg.sclk_s1;
		st_next.sclk_s3 = st_reg.sclk_s2;
		st_next.sdi_s1  = sdio_i;
		st_next.sdi_s2  = st_reg.sdi_s1;
		st_next.line_s1 = ~int_n_i;
		st_next.line_s2 = st_reg.line_s1;
		st_next.cnt_wr  = 1'b0;

		// serial frame: mode nibble, address nibble, bytes
		if (!st_reg.ce_s2) begin
			st_next.phase   = rta_pkg::RTA_IDLE;
			st_next.bit_cnt = `RTA_CNT_ZERO;
		end else begin
			case (st_reg.phase)
				rta_pkg::RTA_IDLE: begin
					st_next.phase   = rta_pkg::RTA_MODE; // see (R19)
					st_next.bit_cnt = `RTA_CNT_ZERO;
				end
				rta_pkg::RTA_MODE: begin
					if (sclk_rise) begin
						st_next.shift   = shift_in;
						st_next.bit_cnt = st_reg.bit_cnt + `RTA_CNT_ONE;
						if (st_reg.bit_cnt == `RTA_NIB_LAST) begin
							st_next.read_mode = shift_in[`RTA_BIT_MODE_RD];
							st_next.phase     = rta_pkg::RTA_ADDR;
							st_next.bit_cnt   = `RTA_CNT_ZERO;
						end
					end
				end
				rta_pkg::RTA_ADDR: begin
					if (sclk_rise) begin
						st_next.shift   = shift_in;
						st_next.bit_cnt = st_reg.bit_cnt + `RTA_CNT_ONE;
						if (st_reg.bit_cnt == `RTA_NIB_LAST) begin
							st_next.addr     = shift_in[3:0]; // see (R19)
							st_next.phase    = rta_pkg::RTA_DATA;
							st_next.bit_cnt  = `RTA_CNT_ZERO;
							st_next.rd_shift = reg_read(st_reg, counters, shift_in[3:0]);
						end
					end
				end
				rta_pkg::RTA_DATA: begin
					if (sclk_rise) begin
						st_next.shift    = shift_in;
						st_next.bit_cnt  = st_reg.bit_cnt + `RTA_CNT_ONE;
						st_next.rd_shift = {st_reg.rd_shift[6:0], 1'b0};
						if (st_reg.bit_cnt == `RTA_BYTE_LAST) begin
							st_next.addr = addr_inc; // see (R19)
							if (st_reg.read_mode) begin
								st_next.rd_shift = reg_read(st_reg, counters, addr_inc);
							end
						end
					end
				end
				default: begin
					st_next.phase = rta_pkg::RTA_IDLE;
				end
			endcase
		end

		// register writes
		if (wr_en) begin
			case (wr_addr)
				`RTA_ADR_MIN, `RTA_ADR_HOUR, `RTA_ADR_WDAY, `RTA_ADR_DATE: begin
					st_next.cnt_wr      = 1'b1;
					st_next.cnt_wr_addr = wr_addr;
					st_next.cnt_wr_data = wr_data;
				end
				`RTA_ADR_MIN_AL:  st_next.min_alarm = wr_data; // see (R15)
				`RTA_ADR_HOUR_AL: st_next.hour_alarm = wr_data; // see (R16)
				`RTA_ADR_DAY_AL:  st_next.day_alarm = wr_data;
				`RTA_ADR_EXT:     st_next.extension_control = wr_data;
				`RTA_ADR_FLAG: begin
					if (!wr_data[`RTA_BIT_AFLAG]) begin
						st_next.alarm_flag = 1'b0; // see (R4)
					end
				end
				`RTA_ADR_CTRL:    st_next.interrupt_control = wr_data & `RTA_MASK_CTRL;
				default: begin
				end
			endcase
		end

		// set wins over a clear in the same cycle
		if (alarm_event) begin
			st_next.alarm_flag = 1'b1; // see (R3)
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sdio_o       = st_reg.rd_shift[7];
	assign sdio_oe      = st_reg.ce_s2 & st_reg.read_mode & (st_reg.phase == rta_pkg::RTA_DATA);
	assign int_n_o      = 1'b0; // open drain, low only
	// released at once when flag or enable drops
	assign int_n_oe     = st_reg.alarm_flag & st_reg.interrupt_control[`RTA_BIT_AIE]; // see (R5) (R6) (R7) (R8)
	assign int_line_low = st_reg.line_s2; // see (R9)
	assign cnt_wr       = st_reg.cnt_wr;
	assign cnt_wr_addr  = st_reg.cnt_wr_addr;
	assign cnt_wr_data  = st_reg.cnt_wr_data;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic aie_now;
	logic all_off;
	assign aie_now = st_reg.interrupt_control[`RTA_BIT_AIE];
	assign all_off = st_reg.min_alarm[`RTA_BIT_DISABLE] & st_reg.hour_alarm[`RTA_BIT_DISABLE]
	                 & st_reg.day_alarm[`RTA_BIT_DISABLE];

	property p_no_event_without_tick;
		!minute_tick && !st_reg.alarm_flag && !wr_en |=> !st_reg.alarm_flag;
	endproperty
	a_no_event_without_tick: assert property (p_no_event_without_tick) // see (R2) (R20)
		else $error("alarm flag set without a minute update");

	property p_event_sets_flag;
		minute_tick && all_off && !st_reg.interrupt_control[`RTA_BIT_SWRST] |=> st_reg.alarm_flag;
	endproperty
	a_event_sets_flag: assert property (p_event_sets_flag) // see (R3) (R14)
		else $error("every-minute alarm did not set flag");

	property p_flag_holds;
		st_reg.alarm_flag && !(wr_en && wr_addr == `RTA_ADR_FLAG && !wr_data[`RTA_BIT_AFLAG])
		|=> st_reg.alarm_flag;
	endproperty
	a_flag_holds: assert property (p_flag_holds) // see (R3) (R4)
		else $error("alarm flag dropped without a zero write");

	property p_one_write_no_set;
		!st_reg.alarm_flag && !alarm_event && wr_en && wr_addr == `RTA_ADR_FLAG
		|=> !st_reg.alarm_flag;
	endproperty
	a_one_write_no_set: assert property (p_one_write_no_set) // see (R4)
		else $error("flag write set the alarm flag");

	property p_swrst_blocks;
		st_reg.interrupt_control[`RTA_BIT_SWRST] && !st_reg.alarm_flag && !wr_en
		|=> !st_reg.alarm_flag;
	endproperty
	a_swrst_blocks: assert property (p_swrst_blocks) // see (R10)
		else $error("alarm event during soft reset");

	property p_irq_on_event;
		alarm_event && aie_now && !(wr_en && wr_addr == `RTA_ADR_CTRL) |=> int_n_oe;
	endproperty
	a_irq_on_event: assert property (p_irq_on_event) // see (R5)
		else $error("enabled alarm did not pull interrupt low");

	property p_aie_release;
		$fell(aie_now) |-> !int_n_oe;
	endproperty
	a_aie_release: assert property (p_aie_release) // see (R6)
		else $error("interrupt held after enable cleared");

	property p_flag_release;
		$fell(st_reg.alarm_flag) |-> !int_n_oe;
	endproperty
	a_flag_release: assert property (p_flag_release) // see (R7)
		else $error("interrupt held after flag cleared");

	property p_disabled_quiet;
		!aie_now |-> !int_n_oe && !int_n_o;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) // see (R8)
		else $error("interrupt driven while disabled");

	property p_weekday_none;
		minute_tick && !st_reg.extension_control[`RTA_BIT_DAYSEL]
		&& st_reg.day_alarm == `RTA_RST_BYTE && !st_reg.alarm_flag && !wr_en
		|=> !st_reg.alarm_flag;
	endproperty
	a_weekday_none: assert property (p_weekday_none) // see (R11) (R12)
		else $error("weekday alarm matched with no day selected");

	property p_drive_in_frame;
		sdio_oe |-> st_reg.ce_s2;
	endproperty
	a_drive_in_frame: assert property (p_drive_in_frame) // see (R19)
		else $error("data pin driven outside a frame");

	c_event_irq: cover property (alarm_event && aie_now ##1 int_n_oe);
	c_event_quiet: cover property (alarm_event && !aie_now);
	c_flag_clear: cover property (st_reg.alarm_flag ##1 !st_reg.alarm_flag);
	c_burst_write: cover property (wr_en ##[1:200] wr_en);

endmodule

// ---- core/rta_consts.svh ----
// How it works
// (R1) alarm event when minute, hour, day all match
// (R2) setting present time gives no immediate event
// (R3) event sets alarm flag; held until cleared
// (R4) writing one to flag does nothing
// (R5) enabled event drives interrupt low, held
// (R6) clearing enable releases interrupt at once
// (R7) clearing flag releases interrupt at once
// (R8) disabled event sets flag, interrupt stays off
// (R9) interrupt line shared with other sources
// (R10) soft reset bit blocks alarm events
// (R11) day target: weekday at zero, date at one
// (R12) weekday alarm bits select any set of days
// (R13) bit seven excludes a field from matching
// (R14) all fields excluded: event every minute
// (R15) alarm values held in bcd
// (R16) spare alarm bit six is plain storage
// (R17) host clears enable before programming alarms
// (R18) unused alarms as storage need enable off
// (R19) serial access: mode, address, data, msb first
// (R20) match detected once, on entering minute
`ifndef RTA_CONSTS_SVH
`define RTA_CONSTS_SVH

// register addresses
`define RTA_ADR_MIN      4'h1
`define RTA_ADR_HOUR     4'h2
`define RTA_ADR_WDAY     4'h3
`define RTA_ADR_DATE     4'h4
`define RTA_ADR_MIN_AL   4'h8
`define RTA_ADR_HOUR_AL  4'h9
`define RTA_ADR_DAY_AL   4'ha
`define RTA_ADR_EXT      4'hd
`define RTA_ADR_FLAG     4'he
`define RTA_ADR_CTRL     4'hf

// field positions
`define RTA_BIT_DISABLE  7
`define RTA_BIT_DAYSEL   6
`define RTA_BIT_AFLAG    3
`define RTA_BIT_AIE      3
`define RTA_BIT_SWRST    0
`define RTA_BIT_MODE_RD  3

// compare masks of bcd fields and weekday bits, writable control bits
`define RTA_MASK_MIN     8'h7f
`define RTA_MASK_HOUR    8'h3f
`define RTA_MASK_DATE    8'h3f
`define RTA_MASK_WDAY    7'h7f
`define RTA_MASK_CTRL    8'hfd

// reset values
`define RTA_RST_BYTE     8'h00
`define RTA_RST_FLAG     1'b0

// serial frame
`define RTA_NIB_LAST     3'h3
`define RTA_BYTE_LAST    3'h7
`define RTA_CNT_ZERO     3'h0
`define RTA_CNT_ONE      3'h1
`define RTA_ADR_ONE      4'h1

`endif

// ---- core/rta_pkg.sv ----
package rta_pkg;

	typedef enum logic [1:0] {
		RTA_IDLE,
		RTA_MODE,
		RTA_ADDR,
		RTA_DATA
	} rta_phase_t;

	typedef struct packed {
		logic [7:0] minute;
		logic [7:0] hour;
		logic [7:0] weekday;
		logic [7:0] date;
	} rta_counters_t;

	typedef struct packed {
		logic       ce_s1;
		logic       ce_s2;
		logic       sclk_s1;
		logic       sclk_s2;
		logic       sclk_s3;
		logic       sdi_s1;
		logic       sdi_s2;
		logic       line_s1;
		logic       line_s2;
		rta_phase_t phase;
		logic [2:0] bit_cnt;
		logic       read_mode;
		logic [3:0] addr;
		logic [7:0] shift;
		logic [7:0] rd_shift;
		logic [7:0] min_alarm;
		logic [7:0] hour_alarm;
		logic [7:0] day_alarm;
		logic [7:0] extension_control;
		logic [7:0] interrupt_control;
		logic       alarm_flag;
		logic       cnt_wr;
		logic [3:0] cnt_wr_addr;
		logic [7:0] cnt_wr_data;
	} rta_state_t;

endpackage

// ---- tb/rta_host.sv ----
`timescale 1ns/1ps
module rta_host (
	input  wire logic clk,
	output logic      ce,
	output logic      sclk,
	output logic      sdo,
	input  wire logic sdi
);
	initial begin
		ce = 1'b0;
		sclk = 1'b0;
		sdo = 1'b0;
	end

	// four system clocks per serial half period
	task automatic half(input logic lvl);
		sclk <= lvl;
		repeat (4) @(posedge clk);
	endtask

	task automatic put(input logic b);
		sdo <= b;
		half(1'b0);
		half(1'b1);
	endtask

	// one frame: mode nibble, address nibble, one byte, msb first
	task automatic xfer(input logic rd, input logic [3:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [7:0] hdr;
		int         i;
		hdr = {rd, 3'h0, a};
		q = 8'h00;
		@(posedge clk);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		for (i = 7; i >= 0; i--) begin
			put(hdr[i]);
		end
		for (i = 7; i >= 0; i--) begin
			if (!rd) begin
				put(wd[i]);
			end else begin
				// released line: keep it moving so a stale level is never trusted
				sdo <= ~sdo;
				sclk <= 1'b0;
				repeat (3) @(posedge clk);
				@(negedge clk) q = {q[6:0], sdi};
				@(posedge clk);
				half(1'b1);
			end
		end
		half(1'b0);
		ce <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask
endmodule

// ---- tb/tb_rta_alarm.sv ----
`timescale 1ns/1ps
module tb_rta_alarm;
	logic                   clk, rst, ce, sclk, host_d, other_low, minute_tick;
	logic                   sdio_o, sdio_oe, int_n_o, int_n_oe, int_line_low, cnt_wr;
	logic [3:0]             cnt_wr_addr;
	logic [7:0]             cnt_wr_data, d;
	rta_pkg::rta_counters_t counters;
	int                     bad_count = 0;
	int                     checked = 0;
	wire                    sdio = sdio_oe ? sdio_o : host_d;
	wire                    int_n = (int_n_oe ? int_n_o : 1'b1) & ~other_low;

	rta_alarm rta_alarm_inst (
		.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .sdio_i(sdio), .sdio_o(sdio_o),
		.sdio_oe(sdio_oe), .int_n_i(int_n), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
		.int_line_low(int_line_low), .counters(counters), .minute_tick(minute_tick),
		.cnt_wr(cnt_wr), .cnt_wr_addr(cnt_wr_addr), .cnt_wr_data(cnt_wr_data)
	);
	rta_host rta_host_inst (.clk(clk), .ce(ce), .sclk(sclk), .sdo(host_d), .sdi(sdio));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		rta_host_inst.xfer(1'b0, a, v, d);
	endtask

	task automatic rd(input logic [3:0] a);
		rta_host_inst.xfer(1'b1, a, 8'h00, d);
	endtask

	task automatic tick(input logic [7:0] m, h, w, dt);
		@(posedge clk);
		counters <= {m, h, w, dt};
		@(posedge clk);
		minute_tick <= 1'b1;
		@(posedge clk);
		minute_tick <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic t_regs();
		wr(4'h9, 8'h7f);
		rd(4'h9); chk("hour alarm", d, 8'h7f);
		wr(4'hf, 8'h02);
		rd(4'hf); chk("control", d, 8'h00);
		wr(4'h5, 8'hff);
		rd(4'h5); chk("unmapped", d, 8'h00);
		wr(4'he, 8'hff);
		rd(4'he); chk("flag ones", d, 8'h00);
		wr(4'h1, 8'h45);
		chk("cnt addr", {4'h0, cnt_wr_addr}, 8'h01);
		chk("cnt data", cnt_wr_data, 8'h45);
	endtask

	task automatic t_week();
		wr(4'hf, 8'h00);
		wr(4'hd, 8'h00);
		wr(4'h8, 8'h30);
		wr(4'h9, 8'h07);
		wr(4'ha, 8'h3e);
		tick(8'h30, 8'h07, 8'h01, 8'h01);
		rd(4'he); chk("unselected day", d, 8'h00);
		tick(8'h30, 8'h07, 8'h04, 8'h01);
		rd(4'he); chk("weekday match", d, 8'h08);
		chk("masked irq", {7'h0, int_n_oe}, 8'h00);
	endtask

	task automatic t_irq();
		wr(4'hf, 8'h08);
		chk("irq drive", {7'h0, int_n_oe}, 8'h01);
		chk("irq wire", {7'h0, int_n}, 8'h00);
		wr(4'hf, 8'h00);
		chk("enable off", {7'h0, int_n_oe}, 8'h00);
		wr(4'hf, 8'h08);
		wr(4'he, 8'h08);
		chk("flag one kept", {7'h0, int_n_oe}, 8'h01);
		wr(4'he, 8'h00);
		chk("flag cleared", {7'h0, int_n_oe}, 8'h00);
		repeat (10) @(posedge clk);
		rd(4'he); chk("no retrigger", d, 8'h00);
		tick(8'h30, 8'h07, 8'h04, 8'h01);
		chk("event irq", {7'h0, int_n_oe}, 8'h01);
		wr(4'he, 8'h00);
		chk("event irq off", {7'h0, int_n_oe}, 8'h00);
	endtask

	task automatic t_date();
		wr(4'hf, 8'h00);
		wr(4'hd, 8'h40);
		wr(4'ha, 8'h15);
		tick(8'h30, 8'h07, 8'h02, 8'h14);
		rd(4'he); chk("date miss", d, 8'h00);
		tick(8'h30, 8'h07, 8'h00, 8'h15);
		rd(4'he); chk("date hit", d, 8'h08);
		wr(4'he, 8'h00);
		wr(4'hd, 8'h00);
		wr(4'ha, 8'h80);
		tick(8'h30, 8'h07, 8'h00, 8'h00);
		rd(4'he); chk("day ignored", d, 8'h08);
		wr(4'he, 8'h00);
		tick(8'h31, 8'h07, 8'h00, 8'h00);
		rd(4'he); chk("minute miss", d, 8'h00);
	endtask

	task automatic t_all();
		wr(4'h8, 8'h80);
		wr(4'h9, 8'h80);
		tick(8'h12, 8'h23, 8'h04, 8'h09);
		rd(4'he); chk("every minute", d, 8'h08);
		wr(4'he, 8'h00);
		wr(4'hf, 8'h01);
		tick(8'h13, 8'h23, 8'h04, 8'h09);
		rd(4'he); chk("soft reset", d, 8'h00);
		wr(4'hf, 8'h00);
		@(posedge clk);
		other_low <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("shared low", {7'h0, int_line_low}, 8'h01);
		@(posedge clk);
		other_low <= 1'b0;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		other_low = 1'b0;
		minute_tick = 1'b0;
		counters = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_regs();
		t_week();
		t_irq();
		t_date();
		t_all();
		test_done();
	end
endmodule
